// file: hdl/hps_pkg.sv
package hps_pkg;

	// ==========================================================
	// Register map
	// ==========================================================
	localparam logic [15:0] HPS_SPLIT_EN_ADDR  = 16'h3c48; // Split enable
	localparam logic [15:0] HPS_P5_SEL_ADDR    = 16'h416e; // Port 5 pin select
	localparam logic [15:0] HPS_P6_SEL_ADDR    = 16'h416f; // Port 6 pin select
	localparam logic [15:0] HPS_TMO_ADDR       = 16'h4171; // Link timeout code
	localparam logic [15:0] HPS_DUR_ADDR       = 16'h4176; // Reset pulse duration code
	localparam logic [15:0] HPS_STAT_ADDR      = 16'h4180; // Watchdog status, read only

	// ==========================================================
	// Reset values
	// ==========================================================
	localparam logic [7:0]  HPS_SPLIT_EN_RST   = 8'h00;
	localparam logic [7:0]  HPS_P5_SEL_RST     = 8'h42;
	localparam logic [7:0]  HPS_P6_SEL_RST     = 8'h06;
	localparam logic [7:0]  HPS_TMO_RST        = 8'h05;
	localparam logic [7:0]  HPS_DUR_RST        = 8'h05;

	// ==========================================================
	// Fields and codes
	// ==========================================================
	localparam int          HPS_P5_BIT         = 5;     // Split enable, port 5
	localparam int          HPS_P6_BIT         = 6;     // Split enable, port 6
	localparam int          HPS_RO_BIT         = 0;     // Read-only reserved bit
	localparam logic [7:0]  HPS_SEL_PIN66      = 8'h42;
	localparam logic [7:0]  HPS_SEL_PIN5       = 8'h05;
	localparam logic [7:0]  HPS_SEL_PIN6       = 8'h06;
	localparam logic [7:0]  HPS_SEL_PIN4       = 8'h04;
	localparam logic [3:0]  HPS_STUCK_LO       = 4'h4;  // Disabled
	localparam logic [3:0]  HPS_STUCK_HI       = 4'h9;  // Hot reset
	localparam logic [7:0]  HPS_TMO_OFF        = 8'h00;

	// ==========================================================
	// Timing
	// ==========================================================
	localparam int          HPS_CLK_PERIOD_NS  = 50;
	localparam int          HPS_MS_NS          = 1000000;
	localparam int          HPS_MS_CYCLES      = HPS_MS_NS / HPS_CLK_PERIOD_NS;
	localparam logic [15:0] HPS_TMO_STEP_MS    = 16'h00c8; // 200 ms per code step
	localparam logic [15:0] HPS_DUR_BASE_MS    = 16'h015e; // 350 ms
	localparam logic [15:0] HPS_DUR_STEP_MS    = 16'h000a; // 10 ms per code step

	// Watchdog states
	typedef enum logic [1:0] {HPS_WD_IDLE, HPS_WD_WATCH, HPS_WD_PULSE} hps_wd_state_e;

	// Link state that counts as not operational
	function automatic logic hps_is_stuck(input logic [3:0] st);
		hps_is_stuck = (st >= HPS_STUCK_LO) && (st <= HPS_STUCK_HI);
	endfunction : hps_is_stuck

	// Code times step, step and result in milliseconds
	function automatic logic [15:0] hps_scale(input logic [7:0] code, input logic [15:0] step);
		hps_scale = 16'({8'h00, code} * step);
	endfunction : hps_scale

endpackage : hps_pkg

// file: hdl/hps_link_watchdog.sv
`timescale 1ns/100ps
module hps_link_watchdog
(
	input  wire logic       core_clk,      // Core clock
	input  wire logic       rst,           // Synchronous reset
	input  wire logic       tick_ms,       // One pulse per millisecond
	input  wire logic       enable,        // Split enabled on this port
	input  wire logic [7:0] timeout_code,  // Timeout select
	input  wire logic [7:0] duration_code, // Pulse duration select
	input  wire logic [3:0] link_state,    // Link state status
	input  wire logic       power_req,     // Port power request from hub core
	output logic            power_on,      // Power level for split pin
	output logic            reset_active   // Low pulse in progress
);
	import hps_pkg::*;

	// ==========================================================
	// State
	// ==========================================================
	hps_wd_state_e state;            // Watchdog phase
	hps_wd_state_e next_state;
	logic [15:0]   cnt;              // Milliseconds elapsed
	logic [15:0]   next_cnt;
	logic [3:0]    last_state;       // Link state seen last cycle
	logic [3:0]    next_last_state;
	logic          next_power_on;
	logic          next_reset_active;
	logic [15:0]   tmo_ms;           // Timeout limit
	logic [15:0]   dur_ms;           // Pulse length

	// Code to milliseconds; code 5 gives 1 s and 400 ms
	assign tmo_ms = hps_scale(timeout_code, HPS_TMO_STEP_MS);
	assign dur_ms = 16'(HPS_DUR_BASE_MS + hps_scale(duration_code, HPS_DUR_STEP_MS));

	// ==========================================================
	// Next state
	// ==========================================================
	always_comb
	begin
		next_state        = state;
		next_cnt          = cnt;
		next_last_state   = link_state;
		next_power_on     = power_req;
		next_reset_active = 1'b0;
		// Watchdog off: split off or code zero
		if (!enable || timeout_code == HPS_TMO_OFF)
		begin
			next_state = HPS_WD_IDLE;
			next_cnt   = 16'h0000;
		end
		else
		begin
			unique case (state)
				HPS_WD_IDLE:
				begin
					next_state = HPS_WD_WATCH;
					next_cnt   = 16'h0000;
				end
				HPS_WD_WATCH:
				begin
					// Any change or healthy state restarts the wait
					if (!hps_is_stuck(link_state) || link_state != last_state)
						next_cnt = 16'h0000;
					else if (tick_ms)
					begin
						if (16'(cnt + 16'h0001) >= tmo_ms)
						begin
							next_state        = HPS_WD_PULSE;
							next_cnt          = 16'h0000;
							next_power_on     = 1'b0;
							next_reset_active = 1'b1;
						end
						else
							next_cnt = 16'(cnt + 16'h0001);
					end
				end
				HPS_WD_PULSE:
				begin
					// Pin held low for the configured time
					next_power_on     = 1'b0;
					next_reset_active = 1'b1;
					if (tick_ms)
					begin
						if (16'(cnt + 16'h0001) >= dur_ms)
						begin
							// Power restored, fresh timeout
							next_state        = HPS_WD_WATCH;
							next_cnt          = 16'h0000;
							next_power_on     = power_req;
							next_reset_active = 1'b0;
						end
						else
							next_cnt = 16'(cnt + 16'h0001);
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Registers
	// ==========================================================
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			state        <= HPS_WD_IDLE;
			cnt          <= 16'h0000;
			last_state   <= 4'h0;
			power_on     <= 1'b0;
			reset_active <= 1'b0;
		end
		else
		begin
			state        <= next_state;
			cnt          <= next_cnt;
			last_state   <= next_last_state;
			power_on     <= next_power_on;
			reset_active <= next_reset_active;
		end
	end

endmodule : hps_link_watchdog

// file: hdl/hps_port_split.sv
`timescale 1ns/100ps
module hps_port_split
#(
	parameter int MS_CYCLES = hps_pkg::HPS_MS_CYCLES // Clocks per millisecond
)
(
	input  wire logic        core_clk,           // 20 MHz core clock
	input  wire logic        rst,                // Synchronous reset
	input  wire logic        cfg_stage,          // Hub in configuration stage
	input  wire logic        cfg_wr,             // Serial bus register write
	input  wire logic        cfg_rd,             // Serial bus register read
	input  wire logic [15:0] cfg_addr,           // Serial bus register address
	input  wire logic [7:0]  cfg_wdata,          // Serial bus write data
	output logic      [7:0]  cfg_rdata,          // Read data, next cycle
	input  wire logic        otp_wr,             // OTP load strobe
	input  wire logic [15:0] otp_addr,           // OTP load address
	input  wire logic [7:0]  otp_data,           // OTP load data
	input  wire logic        port5_power_req,    // Hub port 5 power request
	input  wire logic        port6_power_req,    // Hub port 6 power request
	input  wire logic [3:0]  port5_link_state,   // Port 5 link state status
	input  wire logic [3:0]  port6_link_state,   // Port 6 link state status
	output logic             port5_power_control_pin, // Port 5 legacy power
	output logic             port6_power_control_pin, // Port 6 legacy power
	output logic             aux_pin_66_out,     // Aux pin 66 level
	output logic             aux_pin_66_oe,      // Aux pin 66 drive enable
	output logic             aux_pin_5_out,      // Aux pin 5 level
	output logic             aux_pin_5_oe,       // Aux pin 5 drive enable
	output logic             aux_pin_6_out,      // Aux pin 6 level
	output logic             aux_pin_6_oe,       // Aux pin 6 drive enable
	output logic             aux_pin_4_out,      // Aux pin 4 level
	output logic             aux_pin_4_oe        // Aux pin 4 drive enable
);
	import hps_pkg::*;

	// ==========================================================
	// Declarations
	// ==========================================================
	logic [7:0]  superspeed_split_enable;      // Split enable
	logic [7:0]  port5_split_pin_select;       // Port 5 aux pin choice
	logic [7:0]  port6_split_pin_select;       // Port 6 aux pin choice
	logic [7:0]  link_timeout_select;          // Timeout code
	logic [7:0]  link_reset_pulse_duration;    // Low pulse code
	logic [7:0]  next_superspeed_split_enable;
	logic [7:0]  next_port5_split_pin_select;
	logic [7:0]  next_port6_split_pin_select;
	logic [7:0]  next_link_timeout_select;
	logic [7:0]  next_link_reset_pulse_duration;
	logic [7:0]  next_cfg_rdata;
	logic        wr_en;                        // Merged write strobe
	logic [15:0] wr_addr;
	logic [7:0]  wr_data;
	logic [15:0] div_cnt;                      // Millisecond divider
	logic [15:0] next_div_cnt;
	logic        tick_ms;                      // One-cycle ms enable
	logic        next_tick_ms;
	logic        p5_en;                        // Port 5 split active
	logic        p6_en;                        // Port 6 split active
	logic        p5_power_on;                  // Watchdog output, port 5
	logic        p6_power_on;                  // Watchdog output, port 6
	logic        p5_reset_active;
	logic        p6_reset_active;
	logic        next_pin5_ctl;
	logic        next_pin6_ctl;
	logic [7:0]  next_aux_out;                 // {66,5,6,4} levels in low bits
	logic [7:0]  next_aux_oe;

	// ==========================================================
	// Write source
	// ==========================================================
	// Serial bus writes only count in the configuration stage; OTP
	// loads win a same-cycle clash since they come from fuses.
	always_comb
	begin
		wr_en   = 1'b0;
		wr_addr = 16'h0000;
		wr_data = 8'h00;
		if (otp_wr)
		begin
			wr_en   = 1'b1;
			wr_addr = otp_addr;
			wr_data = otp_data;
		end
		else if (cfg_wr && cfg_stage)
		begin
			wr_en   = 1'b1;
			wr_addr = cfg_addr;
			wr_data = cfg_wdata;
		end
	end

	// ==========================================================
	// Register file, next values
	// ==========================================================
	always_comb
	begin
		next_superspeed_split_enable   = superspeed_split_enable;
		next_port5_split_pin_select    = port5_split_pin_select;
		next_port6_split_pin_select    = port6_split_pin_select;
		next_link_timeout_select       = link_timeout_select;
		next_link_reset_pulse_duration = link_reset_pulse_duration;
		if (wr_en)
		begin
			unique case (wr_addr)
				HPS_SPLIT_EN_ADDR:
				begin
					// Bit 0 stays zero
					next_superspeed_split_enable             = wr_data;
					next_superspeed_split_enable[HPS_RO_BIT] = 1'b0;
				end
				HPS_P5_SEL_ADDR: next_port5_split_pin_select    = wr_data;
				HPS_P6_SEL_ADDR: next_port6_split_pin_select    = wr_data;
				HPS_TMO_ADDR:    next_link_timeout_select       = wr_data;
				HPS_DUR_ADDR:    next_link_reset_pulse_duration = wr_data;
				default:         ; // Unmapped writes dropped
			endcase
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb
	begin
		next_cfg_rdata = 8'h00;
		if (cfg_rd)
		begin
			unique case (cfg_addr)
				HPS_SPLIT_EN_ADDR: next_cfg_rdata = superspeed_split_enable;
				HPS_P5_SEL_ADDR:   next_cfg_rdata = port5_split_pin_select;
				HPS_P6_SEL_ADDR:   next_cfg_rdata = port6_split_pin_select;
				HPS_TMO_ADDR:      next_cfg_rdata = link_timeout_select;
				HPS_DUR_ADDR:      next_cfg_rdata = link_reset_pulse_duration;
				HPS_STAT_ADDR:     next_cfg_rdata = {6'h00, p6_reset_active, p5_reset_active};
				default:           next_cfg_rdata = 8'h00;
			endcase
		end
	end

	// Register file and read data
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			superspeed_split_enable   <= HPS_SPLIT_EN_RST;
			port5_split_pin_select    <= HPS_P5_SEL_RST;
			port6_split_pin_select    <= HPS_P6_SEL_RST;
			link_timeout_select       <= HPS_TMO_RST;
			link_reset_pulse_duration <= HPS_DUR_RST;
			cfg_rdata                 <= 8'h00;
		end
		else
		begin
			superspeed_split_enable   <= next_superspeed_split_enable;
			port5_split_pin_select    <= next_port5_split_pin_select;
			port6_split_pin_select    <= next_port6_split_pin_select;
			link_timeout_select       <= next_link_timeout_select;
			link_reset_pulse_duration <= next_link_reset_pulse_duration;
			cfg_rdata                 <= next_cfg_rdata;
		end
	end

	// ==========================================================
	// Millisecond divider
	// ==========================================================
	// One shared tick keeps both watchdog counters narrow
	always_comb
	begin
		next_tick_ms = 1'b0;
		next_div_cnt = 16'(div_cnt + 16'h0001);
		if (div_cnt >= 16'(MS_CYCLES - 1))
		begin
			next_div_cnt = 16'h0000;
			next_tick_ms = 1'b1;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			div_cnt <= 16'h0000;
			tick_ms <= 1'b0;
		end
		else
		begin
			div_cnt <= next_div_cnt;
			tick_ms <= next_tick_ms;
		end
	end

	// ==========================================================
	// Link watchdogs, one per splittable port
	// ==========================================================
	// Only bits 5 and 6 have any effect; bit 0 always reads zero, the others are storage only
	assign p5_en = superspeed_split_enable[HPS_P5_BIT];
	assign p6_en = superspeed_split_enable[HPS_P6_BIT];

	hps_link_watchdog u_wd5
	(
		.core_clk      (core_clk),
		.rst           (rst),
		.tick_ms       (tick_ms),
		.enable        (p5_en),
		.timeout_code  (link_timeout_select),
		.duration_code (link_reset_pulse_duration),
		.link_state    (port5_link_state),
		.power_req     (port5_power_req),
		.power_on      (p5_power_on),
		.reset_active  (p5_reset_active)
	);

	hps_link_watchdog u_wd6
	(
		.core_clk      (core_clk),
		.rst           (rst),
		.tick_ms       (tick_ms),
		.enable        (p6_en),
		.timeout_code  (link_timeout_select),
		.duration_code (link_reset_pulse_duration),
		.link_state    (port6_link_state),
		.power_req     (port6_power_req),
		.power_on      (p6_power_on),
		.reset_active  (p6_reset_active)
	);

	// ==========================================================
	// Pin drive
	// ==========================================================
	// Split pins are output only; no sense path exists, so an
	// overcurrent on the SuperSpeed supply goes unnoticed.
	always_comb
	begin
		next_pin5_ctl = port5_power_req;
		next_pin6_ctl = port6_power_req;
		next_aux_out  = 8'h00;
		next_aux_oe   = 8'h00;
		// Bit 3: pin 66, bit 2: pin 5, bit 1: pin 6, bit 0: pin 4
		next_aux_oe[3]  = p5_en && (port5_split_pin_select == HPS_SEL_PIN66);
		next_aux_oe[2]  = p5_en && (port5_split_pin_select == HPS_SEL_PIN5);
		next_aux_oe[1]  = p6_en && (port6_split_pin_select == HPS_SEL_PIN6);
		next_aux_oe[0]  = p6_en && (port6_split_pin_select == HPS_SEL_PIN4);
		next_aux_out[3] = next_aux_oe[3] && p5_power_on;
		next_aux_out[2] = next_aux_oe[2] && p5_power_on;
		next_aux_out[1] = next_aux_oe[1] && p6_power_on;
		next_aux_out[0] = next_aux_oe[0] && p6_power_on;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			port5_power_control_pin <= 1'b0;
			port6_power_control_pin <= 1'b0;
			aux_pin_66_out          <= 1'b0;
			aux_pin_5_out           <= 1'b0;
			aux_pin_6_out           <= 1'b0;
			aux_pin_4_out           <= 1'b0;
			aux_pin_66_oe           <= 1'b0;
			aux_pin_5_oe            <= 1'b0;
			aux_pin_6_oe            <= 1'b0;
			aux_pin_4_oe            <= 1'b0;
		end
		else
		begin
			port5_power_control_pin <= next_pin5_ctl;
			port6_power_control_pin <= next_pin6_ctl;
			aux_pin_66_out          <= next_aux_out[3];
			aux_pin_5_out           <= next_aux_out[2];
			aux_pin_6_out           <= next_aux_out[1];
			aux_pin_4_out           <= next_aux_out[0];
			aux_pin_66_oe           <= next_aux_oe[3];
			aux_pin_5_oe            <= next_aux_oe[2];
			aux_pin_6_oe            <= next_aux_oe[1];
			aux_pin_4_oe            <= next_aux_oe[0];
		end
	end

endmodule : hps_port_split

// file: verif/hps_port_split_monitor.sv
`timescale 1ns/100ps
module hps_port_split_monitor
	import hps_pkg::*;
#(
	parameter int MS_CYCLES = 4 // Clocks per millisecond
)
(
	input logic        core_clk,
	input logic        rst,
	input logic        cfg_rd,
	input logic [15:0] cfg_addr,
	input logic [7:0]  cfg_rdata,
	input logic        port5_power_req,
	input logic        port6_power_req,
	input logic [3:0]  port5_link_state,
	input logic        port5_power_control_pin,
	input logic        port6_power_control_pin,
	input logic        aux_pin_66_out,
	input logic        aux_pin_66_oe,
	input logic        aux_pin_5_oe,
	input logic        aux_pin_6_oe,
	input logic        aux_pin_4_oe
);
	// ==========================================================
	// Low run counter on pin 66
	// ==========================================================
	localparam int LOW_MIN = 350 * MS_CYCLES;      // Shortest legal pulse
	localparam int LOW_MAX = 2900 * MS_CYCLES + 8; // Longest pulse plus slack
	logic [31:0] low_run;      // Cycles low while powered and driven
	logic [31:0] next_low_run;
	// Counts only while power is requested, so a request drop never looks like a pulse
	always_comb
	begin
		next_low_run = (aux_pin_66_oe && !aux_pin_66_out && port5_power_req) ? low_run + 32'd1 : 32'd0;
	end
	always_ff @(posedge core_clk)
	begin
		low_run <= rst ? 32'd0 : next_low_run;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	// ==========================================================
	// Properties
	// ==========================================================
	sequence s_req_held;
		port5_power_req [*4];
	endsequence
	sequence s_drop_66;
		$fell(aux_pin_66_out) && aux_pin_66_oe && $past(aux_pin_66_oe);
	endsequence
	a_legacy5_follows: assert property (!$past(rst) |-> port5_power_control_pin == $past(port5_power_req))
		else $error("port 5 legacy power pin does not follow request");
	a_legacy6_follows: assert property (!$past(rst) |-> port6_power_control_pin == $past(port6_power_req))
		else $error("port 6 legacy power pin does not follow request");
	a_port5_one_pin: assert property (!(aux_pin_66_oe && aux_pin_5_oe))
		else $error("port 5 split power drives two pins");
	a_port6_one_pin: assert property (!(aux_pin_6_oe && aux_pin_4_oe))
		else $error("port 6 split power drives two pins");
	a_out_needs_oe: assert property (aux_pin_66_out |-> aux_pin_66_oe)
		else $error("pin 66 high while not driven");
	a_rdata_idle: assert property (!$past(cfg_rd) |-> cfg_rdata == 8'h00)
		else $error("read data not zero without a read");
	a_enable_bit_zero: assert property (cfg_rd && cfg_addr == HPS_SPLIT_EN_ADDR |=> cfg_rdata[HPS_RO_BIT] == 1'b0)
		else $error("split enable bit 0 read as one");
	a_drop_when_stuck: assert property (s_req_held ##0 s_drop_66 |-> port5_link_state >= 4'h4 && port5_link_state <= 4'h9)
		else $error("pin 66 pulsed with a healthy link");
	a_low_minimum: assert property ($rose(aux_pin_66_out) && aux_pin_66_oe && port5_power_req && low_run > 32'd4
		|-> low_run >= LOW_MIN)
		else $error("reset pulse shorter than minimum");
	a_low_maximum: assert property (aux_pin_66_oe |-> low_run <= LOW_MAX)
		else $error("reset pulse longer than maximum");
endmodule : hps_port_split_monitor

bind hps_port_split hps_port_split_monitor #(.MS_CYCLES(MS_CYCLES)) mon_u (.core_clk(core_clk), .rst(rst),
	.cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata), .port5_power_req(port5_power_req),
	.port6_power_req(port6_power_req), .port5_link_state(port5_link_state),
	.port5_power_control_pin(port5_power_control_pin), .port6_power_control_pin(port6_power_control_pin),
	.aux_pin_66_out(aux_pin_66_out), .aux_pin_66_oe(aux_pin_66_oe), .aux_pin_5_oe(aux_pin_5_oe),
	.aux_pin_6_oe(aux_pin_6_oe), .aux_pin_4_oe(aux_pin_4_oe));

// file: verif/hps_ss_device_model.sv
`timescale 1ns/100ps
module hps_ss_device_model
(
	input  wire logic       core_clk,   // Core clock
	input  wire logic       rst,        // Synchronous reset
	input  wire logic       power,      // Split power level seen by the device
	input  wire logic       stuck,      // Never finish training
	output logic      [3:0] link_state  // Link state status
);
	// ==========================================================
	// Link training
	// ==========================================================
	logic [1:0] train; // Cycles spent polling
	// Unpowered reads as disabled; a broken device polls forever
	always_ff @(posedge core_clk)
	begin
		if (rst || !power)
		begin
			train      <= 2'h0;
			link_state <= 4'h4;
		end
		else if (stuck || train != 2'h3)
		begin
			train      <= stuck ? 2'h0 : train + 2'h1;
			link_state <= 4'h7;
		end
		else
			link_state <= 4'h0; // Operational link
	end
endmodule : hps_ss_device_model

// file: verif/hps_port_split_tb.sv
`timescale 1ns/100ps
module testbench;
	import hps_pkg::*;
	// ==========================================================
	// Signals
	// ==========================================================
	localparam int MS = 4;      // Shortened millisecond
	logic        core_clk = 1'b0;
	logic        rst, cfg_stage, cfg_wr, cfg_rd, otp_wr, p5_req, p6_req;
	logic [15:0] cfg_addr, otp_addr;
	logic [7:0]  cfg_wdata, otp_data, cfg_rdata;
	logic [3:0]  p5_link, p6_link;
	logic        pc5, pc6, o66, e66, o5, e5, o6, e6, o4, e4;
	logic        watch6 = 1'b0; // Healthy port watch armed
	logic        p6_fell = 1'b0; // Healthy port lost power
	int          errors = 0;
	int          checks_done = 0;
	int          n;
	logic [7:0]  sel5 [3] = '{8'h42, 8'h05, 8'h11};        // Pin 66, pin 5, unlisted
	logic [7:0]  sel6 [3] = '{8'h06, 8'h04, 8'h07};        // Pin 6, pin 4, unlisted
	logic [3:0]  oe_exp [3] = '{4'b1010, 4'b0101, 4'b0000}; // Enables {66,5,6,4}
	always #25 core_clk = ~core_clk;
	hps_port_split #(.MS_CYCLES(MS)) dut_u (.core_clk(core_clk), .rst(rst), .cfg_stage(cfg_stage),
		.cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
		.otp_wr(otp_wr), .otp_addr(otp_addr), .otp_data(otp_data), .port5_power_req(p5_req),
		.port6_power_req(p6_req), .port5_link_state(p5_link), .port6_link_state(p6_link),
		.port5_power_control_pin(pc5), .port6_power_control_pin(pc6), .aux_pin_66_out(o66),
		.aux_pin_66_oe(e66), .aux_pin_5_out(o5), .aux_pin_5_oe(e5), .aux_pin_6_out(o6), .aux_pin_6_oe(e6),
		.aux_pin_4_out(o4), .aux_pin_4_oe(e4));
	// Port 5 device never trains, port 6 device is healthy
	hps_ss_device_model dev5_u (.core_clk(core_clk), .rst(rst), .power((e66 & o66) | (e5 & o5)),
		.stuck(1'b1), .link_state(p5_link));
	hps_ss_device_model dev6_u (.core_clk(core_clk), .rst(rst), .power((e6 & o6) | (e4 & o4)),
		.stuck(1'b0), .link_state(p6_link));
	// Sampled before the edge updates land
	always @(posedge core_clk)
		if (watch6 && o6 !== 1'b1)
			p6_fell <= 1'b1;
	// ==========================================================
	// Tasks
	// ==========================================================
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Loose window because tick phase is not aligned to the start
	task automatic near(input int got, input int exp);
		check(8'(got >= exp - 12 && got <= exp + 12), 8'h01);
	endtask : near
	// Serial bus write, or OTP load when otp is set
	task automatic wr(input logic otp, input logic [15:0] addr, input logic [7:0] data);
		@(negedge core_clk);
		if (otp)
		begin
			otp_wr   = 1'b1;
			otp_addr = addr;
			otp_data = data;
		end
		else
		begin
			cfg_wr    = 1'b1;
			cfg_addr  = addr;
			cfg_wdata = data;
		end
		@(negedge core_clk);
		otp_wr = 1'b0;
		cfg_wr = 1'b0;
	endtask : wr
	task automatic rchk(input logic [15:0] addr, input logic [7:0] exp);
		@(negedge core_clk);
		cfg_rd = 1'b1; cfg_addr = addr;
		@(negedge core_clk);
		cfg_rd = 1'b0;
		check(cfg_rdata, exp);
	endtask : rchk
	// Wait for pin 66 to reach a level, bounded
	task automatic wt(input logic val, input int max, output int cnt);
		cnt = 0;
		while (o66 !== val && cnt < max)
		begin
			@(negedge core_clk);
			cnt++;
		end
	endtask : wt
	task automatic conclude;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude
	// ==========================================================
	// Watchdog
	// ==========================================================
	initial
	begin
		#1500000;
		errors++;
		conclude();
	end
	// ==========================================================
	// Tests
	// ==========================================================
	initial
	begin
		rst       = 1'b1;
		cfg_stage = 1'b0;
		cfg_wr    = 1'b0;
		cfg_rd    = 1'b0;
		otp_wr    = 1'b0;
		cfg_addr  = 16'h0000;
		otp_addr  = 16'h0000;
		cfg_wdata = 8'h00;
		otp_data  = 8'h00;
		p5_req    = 1'b0;
		p6_req    = 1'b0;
		repeat (4) @(negedge core_clk);
		rst = 1'b0;
		rchk(HPS_SPLIT_EN_ADDR, 8'h00);
		rchk(HPS_P5_SEL_ADDR, HPS_P5_SEL_RST);
		rchk(HPS_P6_SEL_ADDR, HPS_P6_SEL_RST);
		rchk(HPS_TMO_ADDR, 8'h05);
		rchk(HPS_DUR_ADDR, HPS_DUR_RST);
		rchk(HPS_STAT_ADDR, 8'h00);
		wr(1'b0, HPS_DUR_ADDR, 8'h33);
		rchk(HPS_DUR_ADDR, HPS_DUR_RST);
		cfg_stage = 1'b1;
		wr(1'b0, HPS_SPLIT_EN_ADDR, 8'hff);
		rchk(HPS_SPLIT_EN_ADDR, 8'hfe);
		wr(1'b1, 16'h1234, 8'h5a);
		rchk(16'h1234, 8'h00);
		// Reserved enable bits only: nothing splits
		wr(1'b1, HPS_SPLIT_EN_ADDR, 8'h9e);
		p5_req = 1'b1;
		repeat (2) @(negedge core_clk);
		check({6'h00, pc5, pc6}, 8'h02);
		check({4'h0, e66, e5, e6, e4}, 8'h00);
		p5_req = 1'b0;
		p6_req = 1'b1;
		repeat (2) @(negedge core_clk);
		check({6'h00, pc5, pc6}, 8'h01);
		p5_req = 1'b1;
		wr(1'b0, HPS_SPLIT_EN_ADDR, 8'h60);
		for (int i = 0; i < 3; i++)
		begin
			wr(i[0], HPS_P5_SEL_ADDR, sel5[i]);
			wr(i[0], HPS_P6_SEL_ADDR, sel6[i]);
			repeat (2) @(negedge core_clk);
			check({4'h0, e66, e5, e6, e4}, {4'h0, oe_exp[i]});
			// Both requests high, so every driven pin is powered
			check({4'h0, o66, o5, o6, o4}, {4'h0, oe_exp[i]});
		end
		wr(1'b0, HPS_P6_SEL_ADDR, 8'h06);
		wr(1'b0, HPS_P5_SEL_ADDR, 8'h42);
		repeat (2) @(negedge core_clk);
		check({6'h00, o66, o6}, 8'h03);
		watch6 = 1'b1;
		// Stuck link on port 5: default one second, then 400 ms low
		wt(1'b0, 5000, n);
		near(n, 1000 * MS);
		rchk(HPS_STAT_ADDR, 8'h01);
		wt(1'b1, 2500, n);
		near(n, 400 * MS - 2);
		wr(1'b0, HPS_DUR_ADDR, 8'h00);
		wt(1'b0, 5000, n);
		near(n, 1000 * MS - 2);
		wt(1'b1, 2500, n);
		near(n, 350 * MS);
		wr(1'b1, HPS_TMO_ADDR, 8'h00);
		wt(1'b0, 5000, n);
		check(8'(n == 5000), 8'h01);
		check({7'h00, p6_fell}, 8'h00);
		conclude();
	end
endmodule : testbench
